// >>> hw/somc_mode_ctrl.sv
// output mode control: run / command / diagnostic selection, start window,
// LIN command interpretation and pin direction for the PWM pins.
// assumes: a LIN frame layer decodes requests and serialises answers; inputs
// are synchronous to mclk_i; rst_i is the power-on reset.
//
// Behaviour
// - in normal run only the LIN or the PWM interface is active, not both
// - PWM configured and no enter request in 30 ms: normal run with PWM output
// - after normal run via the PWM path, PWM pins ignore commands until power-up, except in diagnostic mode
// - enter request inside the window moves to command mode and stays there
// - command code 01 runs from nvm, 02 from volatile; both enter normal run
// - in LIN mode an enter request is accepted at any time
// - during the window both PWM pins are recessive and receive data dump frames
// - after the window the PWM pins communicate only in command mode without the PWM lock, or in diagnostic mode
// - enter request is code 72 in a data dump with data 74
// - nvm writes are refused unless the unlock command 6C with F742 came first
// - any detected failure switches into diagnostic mode
// - publisher answers in LIN normal run carry the diagnostic error flag
// - in PWM mode diagnostic mode drives the recessive level of the chosen driver
// - in diagnostic mode LIN is accepted on every output pin
// - read-by-identifier B2, id 20, wildcard FF7F returns the diagnostic error code
// - the LIN pin takes the enter request even while PWM output runs
// - all output pins carry LIN data link framing
// - LIN on the high-side pin uses inverted levels
// - LIN normal run answers publisher requests (not in a cycle with an accepted error read) and transport requests
`timescale 1ns/100ps
module somc_mode_ctrl
    import somc_pkg::*;
#(
    parameter int unsigned TICK_CYC = MS_TICK_CYC
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cfg_pwm_mode_i,
    input wire logic cfg_high_side_i,
    input wire somc_req_t req_i,
    input wire logic pub_req_i,
    input wire logic [15:0] meas_value_i,
    input wire logic fault_i,
    input wire logic [7:0] fault_code_i,
    input wire logic nvm_wr_req_i,
    input wire logic pwm_level_i,
    input wire logic link_tx_en_i,
    input wire logic link_tx_bit_i,
    input wire logic lin_rx_i,
    input wire logic high_side_out_pin_rx_i,
    input wire logic low_side_out_pin_rx_i,
    output somc_mode_t mode_o,
    output logic diag_o,
    output logic pwm_active_o,
    output logic lin_active_o,
    output logic [2:0] listen_o,
    output logic [2:0] rx_bits_o,
    output logic lin_tx_o,
    output logic high_side_out_pin_o,
    output logic high_side_out_pin_oe_n_o,
    output logic low_side_out_pin_o,
    output logic low_side_out_pin_oe_n_o,
    output logic meas_start_o,
    output logic meas_from_nvm_o,
    output logic nvm_wr_grant_o,
    output logic nvm_wr_refuse_o,
    output somc_resp_t resp_o
);

    function automatic somc_cmd_t decode_req(input somc_req_t r);
        somc_cmd_t c;
        c = SOMC_CMD_NONE;
        if (r.valid && r.sid == SID_DATA_DUMP)
        begin
            if (r.code == CODE_ENTER_CMD && r.data[15:8] == DATA_ENTER_CMD)
                c = SOMC_CMD_ENTER;
            else if (r.code == CODE_NVM_UNLOCK && r.data == DATA_NVM_UNLOCK)
                c = SOMC_CMD_UNLOCK;
            else if (r.code == CODE_RUN_NVM)
                c = SOMC_CMD_RUN_NVM;
            else if (r.code == CODE_RUN_VOLATILE)
                c = SOMC_CMD_RUN_VOL;
        end
        else if (r.valid && r.sid == SID_READ_BY_ID && r.code == ID_ERROR_STATUS
                 && r.data == WILDCARD_ERROR)
            c = SOMC_CMD_ERR_READ;
        return c;
    endfunction : decode_req

    somc_mode_t state_ff;
    somc_mode_t nxt_state;
    logic started_ff;
    logic win_expired;
    logic pwm_locked_ff;
    logic diag_ff;
    logic [7:0] fault_code_ff;
    logic unlock_ff;
    logic [1:0] reply_pin_ff;
    logic meas_start_ff;
    logic meas_from_nvm_ff;
    logic nvm_grant_ff;
    logic nvm_refuse_ff;
    somc_resp_t resp_ff;
    somc_cmd_t cmd;
    logic from_pwm_pin;
    logic pin_ok;
    logic accepted;
    logic pwm_run;
    logic tx_high;
    logic tx_low;

    // the window starts counting at the first cycle after reset release
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            started_ff <= 1'b0;
        else
            started_ff <= 1'b1;
    end

    somc_start_timer #(
        .TICK_CYC(TICK_CYC),
        .TICKS(WINDOW_TICKS)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(started_ff),
        .expired_o(win_expired)
    );

    assign cmd = decode_req(req_i);
    assign from_pwm_pin = (req_i.pin == PIN_HIGH) || (req_i.pin == PIN_LOW);
    assign pwm_run = cfg_pwm_mode_i && (state_ff == SOMC_MODE_RUN);

    // which requests the current mode lets in, by the pin they came on
    always_comb
    begin
        pin_ok = 1'b0;
        if (diag_ff)
            pin_ok = 1'b1;
        else if (from_pwm_pin)
            pin_ok = (state_ff == SOMC_MODE_WINDOW && cmd == SOMC_CMD_ENTER)
                  || (state_ff == SOMC_MODE_COMMAND && !pwm_locked_ff);
        else if (req_i.pin == PIN_LIN)
            pin_ok = !pwm_run || cmd == SOMC_CMD_ENTER;
    end

    assign accepted = req_i.valid && pin_ok && (cmd != SOMC_CMD_NONE);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SOMC_MODE_WINDOW:
            begin
                if (accepted && cmd == SOMC_CMD_ENTER)
                    nxt_state = SOMC_MODE_COMMAND;
                else if (!cfg_pwm_mode_i || win_expired)
                    nxt_state = SOMC_MODE_RUN;
            end
            SOMC_MODE_COMMAND:
            begin
                if (accepted && (cmd == SOMC_CMD_RUN_NVM || cmd == SOMC_CMD_RUN_VOL))
                    nxt_state = SOMC_MODE_RUN;
            end
            SOMC_MODE_RUN:
            begin
                if (accepted && cmd == SOMC_CMD_ENTER)
                    nxt_state = SOMC_MODE_COMMAND;
            end
            default:
                nxt_state = SOMC_MODE_WINDOW;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            state_ff <= SOMC_MODE_WINDOW;
        else
            state_ff <= nxt_state;
    end

    // once run starts through the PWM path, the PWM pins stay closed until power-up, except in diagnostic mode
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            pwm_locked_ff <= 1'b0;
        else if (state_ff == SOMC_MODE_WINDOW && nxt_state == SOMC_MODE_RUN
                 && cfg_pwm_mode_i)
            pwm_locked_ff <= 1'b1;
    end

    // diagnostic mode is sticky; the first failure's code is kept
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            diag_ff <= 1'b0;
            fault_code_ff <= FAULT_CODE_NONE;
        end
        else if (fault_i && !diag_ff)
        begin
            diag_ff <= 1'b1;
            fault_code_ff <= fault_code_i;
        end
    end

    // nvm unlock lives only as long as command mode
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || state_ff != SOMC_MODE_COMMAND)
            unlock_ff <= 1'b0;
        else if (accepted && cmd == SOMC_CMD_UNLOCK)
            unlock_ff <= 1'b1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            nvm_grant_ff <= 1'b0;
            nvm_refuse_ff <= 1'b0;
        end
        else
        begin
            nvm_grant_ff <= nvm_wr_req_i && unlock_ff;
            nvm_refuse_ff <= nvm_wr_req_i && !unlock_ff;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            meas_start_ff <= 1'b0;
            meas_from_nvm_ff <= 1'b0;
        end
        else
        begin
            meas_start_ff <= state_ff == SOMC_MODE_COMMAND && nxt_state == SOMC_MODE_RUN;
            if (state_ff == SOMC_MODE_COMMAND && nxt_state == SOMC_MODE_RUN)
                meas_from_nvm_ff <= (cmd == SOMC_CMD_RUN_NVM);
        end
    end

    // answers go back on the pin the request came on
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            reply_pin_ff <= PIN_LIN;
        else if (accepted)
            reply_pin_ff <= req_i.pin;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            resp_ff <= '{valid: 1'b0, is_publisher: 1'b0, err_flag: 1'b0,
                         pin: PIN_LIN, data: RESP_DATA_RST};
        else if (accepted && cmd == SOMC_CMD_ERR_READ)
            resp_ff <= '{valid: 1'b1, is_publisher: 1'b0, err_flag: diag_ff,
                         pin: req_i.pin, data: {8'h00, fault_code_ff}};
        else if (pub_req_i && !cfg_pwm_mode_i && state_ff == SOMC_MODE_RUN)
            resp_ff <= '{valid: 1'b1, is_publisher: 1'b1, err_flag: diag_ff,
                         pin: PIN_LIN, data: meas_value_i};
        else
            resp_ff.valid <= 1'b0;
    end

    // pin listening and receive levels for the frame layer
    always_comb
    begin
        listen_o[PIN_LIN] = 1'b1;
        listen_o[PIN_HIGH] = diag_ff || state_ff == SOMC_MODE_WINDOW
                          || (state_ff == SOMC_MODE_COMMAND && !pwm_locked_ff);
        listen_o[PIN_LOW] = listen_o[PIN_HIGH];
        rx_bits_o[PIN_LIN] = lin_rx_i;
        rx_bits_o[PIN_HIGH] = ~high_side_out_pin_rx_i;
        rx_bits_o[PIN_LOW] = low_side_out_pin_rx_i;
    end

    // a dominant LIN bit pulls the low-side pin down and, inverted, the high-side pin up
    assign tx_high = link_tx_en_i && reply_pin_ff == PIN_HIGH && listen_o[PIN_HIGH]
                  && state_ff != SOMC_MODE_WINDOW && !link_tx_bit_i;
    assign tx_low = link_tx_en_i && reply_pin_ff == PIN_LOW && listen_o[PIN_LOW]
                 && state_ff != SOMC_MODE_WINDOW && !link_tx_bit_i;

    // PWM pulses only in normal run with no failure; diag leaves the recessive level
    assign pwm_active_o = pwm_run && !diag_ff;
    assign lin_active_o = !pwm_active_o;

    always_comb
    begin
        high_side_out_pin_o = 1'b1;
        high_side_out_pin_oe_n_o = 1'b1;
        low_side_out_pin_o = 1'b0;
        low_side_out_pin_oe_n_o = 1'b1;
        if (pwm_active_o && cfg_high_side_i)
            high_side_out_pin_oe_n_o = ~pwm_level_i;
        else if (pwm_active_o)
            low_side_out_pin_oe_n_o = ~pwm_level_i;
        else
        begin
            high_side_out_pin_oe_n_o = ~tx_high;
            low_side_out_pin_oe_n_o = ~tx_low;
        end
    end

    assign lin_tx_o = !(link_tx_en_i && reply_pin_ff == PIN_LIN && !link_tx_bit_i);
    assign mode_o = diag_ff ? SOMC_MODE_DIAG : state_ff;
    assign diag_o = diag_ff;
    assign meas_start_o = meas_start_ff;
    assign meas_from_nvm_o = meas_from_nvm_ff;
    assign nvm_wr_grant_o = nvm_grant_ff;
    assign nvm_wr_refuse_o = nvm_refuse_ff;
    assign resp_o = resp_ff;

    sequence s_enter_on_pin;
        req_i.valid && cmd == SOMC_CMD_ENTER && state_ff == SOMC_MODE_WINDOW;
    endsequence

    property p_window_enter;
        @(posedge mclk_i) disable iff (rst_i)
        s_enter_on_pin |=> state_ff == SOMC_MODE_COMMAND;
    endproperty
    a_window_enter: assert property (p_window_enter) else $error("enter missed");

    property p_lock_ignores;
        @(posedge mclk_i) disable iff (rst_i)
        pwm_locked_ff && !diag_ff && from_pwm_pin && req_i.valid |-> !accepted;
    endproperty
    a_lock_ignores: assert property (p_lock_ignores) else $error("locked pin took frame");

    property p_exclusive;
        @(posedge mclk_i) disable iff (rst_i)
        pwm_active_o |-> !lin_active_o && state_ff == SOMC_MODE_RUN;
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("pwm and lin both on");

    property p_fault_diag;
        @(posedge mclk_i) disable iff (rst_i)
        fault_i |=> diag_o && mode_o == SOMC_MODE_DIAG;
    endproperty
    a_fault_diag: assert property (p_fault_diag) else $error("fault not in diag");

    property p_refuse;
        @(posedge mclk_i) disable iff (rst_i)
        nvm_wr_req_i && !unlock_ff |=> nvm_wr_refuse_o && !nvm_wr_grant_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("locked nvm write granted");

    property p_window_quiet;
        @(posedge mclk_i) disable iff (rst_i)
        state_ff == SOMC_MODE_WINDOW |-> high_side_out_pin_oe_n_o && low_side_out_pin_oe_n_o;
    endproperty
    a_window_quiet: assert property (p_window_quiet) else $error("pin driven in window");

    property p_run_start;
        @(posedge mclk_i) disable iff (rst_i)
        state_ff == SOMC_MODE_COMMAND && accepted && cmd == SOMC_CMD_RUN_VOL
        |=> meas_start_o && !meas_from_nvm_o ##1 !meas_start_o;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run from volatile");

    property p_err_read;
        @(posedge mclk_i) disable iff (rst_i)
        accepted && cmd == SOMC_CMD_ERR_READ
        |=> resp_o.valid && resp_o.data[7:0] == $past(fault_code_ff);
    endproperty
    a_err_read: assert property (p_err_read) else $error("error code wrong");

    property p_expire_run;
        @(posedge mclk_i) disable iff (rst_i)
        state_ff == SOMC_MODE_WINDOW && win_expired && !accepted
        |=> state_ff == SOMC_MODE_RUN && pwm_locked_ff == cfg_pwm_mode_i;
    endproperty
    a_expire_run: assert property (p_expire_run) else $error("window expiry");

endmodule : somc_mode_ctrl

// >>> hw/somc_pkg.sv
// package: constants, command codes and carrier types of the output mode control
// assumes: one 250 MHz clock, synchronous active-high reset
package somc_pkg;

    localparam int unsigned CLK_KHZ = 250000;
    localparam int unsigned START_WINDOW_MS = 30;
    localparam int unsigned MS_TICK_CYC = CLK_KHZ;
    localparam int unsigned WINDOW_TICKS = START_WINDOW_MS;
    localparam int unsigned TICK_CNT_W = 18;
    localparam int unsigned WIN_CNT_W = 6;

    // transport-layer service identifiers
    localparam logic [7:0] SID_DATA_DUMP = 8'hB4;
    localparam logic [7:0] SID_READ_BY_ID = 8'hB2;

    // data dump command codes and their companion data
    localparam logic [7:0] CODE_ENTER_CMD = 8'h72;
    localparam logic [7:0] DATA_ENTER_CMD = 8'h74;
    localparam logic [7:0] CODE_NVM_UNLOCK = 8'h6C;
    localparam logic [15:0] DATA_NVM_UNLOCK = 16'hF742;
    localparam logic [7:0] CODE_RUN_NVM = 8'h01;
    localparam logic [7:0] CODE_RUN_VOLATILE = 8'h02;

    // read-by-identifier error status request
    localparam logic [7:0] ID_ERROR_STATUS = 8'h20;
    localparam logic [15:0] WILDCARD_ERROR = 16'hFF7F;

    localparam logic [7:0] FAULT_CODE_NONE = 8'h00;
    localparam logic [15:0] RESP_DATA_RST = 16'h0000;

    // pin indices
    localparam logic [1:0] PIN_LIN = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_LOW = 2'h2;

    typedef enum logic [1:0] {
        SOMC_MODE_WINDOW,
        SOMC_MODE_COMMAND,
        SOMC_MODE_RUN,
        SOMC_MODE_DIAG
    } somc_mode_t;

    typedef enum logic [2:0] {
        SOMC_CMD_NONE,
        SOMC_CMD_ENTER,
        SOMC_CMD_UNLOCK,
        SOMC_CMD_RUN_NVM,
        SOMC_CMD_RUN_VOL,
        SOMC_CMD_ERR_READ
    } somc_cmd_t;

    // one decoded LIN transport-layer request
    typedef struct packed {
        logic valid;
        logic [1:0] pin;
        logic [7:0] sid;
        logic [7:0] code;
        logic [15:0] data;
    } somc_req_t;

    // one answer handed back to the frame layer
    typedef struct packed {
        logic valid;
        logic is_publisher;
        logic err_flag;
        logic [1:0] pin;
        logic [15:0] data;
    } somc_resp_t;

endpackage : somc_pkg

// >>> hw/somc_start_timer.sv
// start window timer: millisecond enable divider and a window tick counter
// assumes: start_i is high from the cycle after reset release onward
`timescale 1ns/100ps
module somc_start_timer
    import somc_pkg::*;
#(
    parameter int unsigned TICK_CYC = MS_TICK_CYC,
    parameter int unsigned TICKS = WINDOW_TICKS
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic expired_o
);

    logic [TICK_CNT_W-1:0] div_ff;
    logic [WIN_CNT_W-1:0] ticks_ff;
    logic ms_tick;

    assign ms_tick = start_i && !expired_o && (div_ff == TICK_CNT_W'(TICK_CYC - 1));

    // divider making a one-cycle millisecond enable
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || ms_tick)
            div_ff <= '0;
        else if (start_i && !expired_o)
            div_ff <= div_ff + TICK_CNT_W'(1);
    end

    // window closes once the nominal tick count is reached
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ticks_ff <= '0;
        else if (ms_tick)
            ticks_ff <= ticks_ff + WIN_CNT_W'(1);
    end

    assign expired_o = (ticks_ff == WIN_CNT_W'(TICKS));

endmodule : somc_start_timer

// >>> tb/somc_lin_master.sv
// partner: lin master or calibration rig, seen through the frame layer
// assumes: requests change just after the rising edge of mclk_i
`timescale 1ns/100ps
module somc_lin_master
    import somc_pkg::*;
(
    input wire logic mclk_i,
    output somc_req_t req_o,
    output logic pub_o,
    output logic [2:0] rx_o
);
    // idle lines: lin and low pin recessive high, high pin inverted
    initial
    begin
        req_o = '0;
        pub_o = 1'b0;
        rx_o = 3'b101;
    end

    task automatic send(input logic [1:0] pin, input logic [7:0] sid,
        input logic [7:0] code, input logic [15:0] data);
        @(posedge mclk_i);
        req_o <= '{1'b1, pin, sid, code, data};
        @(posedge mclk_i);
        req_o.valid <= 1'b0;
    endtask : send

    task automatic enter(input logic [1:0] pin);
        send(pin, SID_DATA_DUMP, CODE_ENTER_CMD, 16'h74FF);
    endtask : enter

    task automatic unlock;
        send(PIN_LIN, SID_DATA_DUMP, CODE_NVM_UNLOCK, DATA_NVM_UNLOCK);
    endtask : unlock

    task automatic pub;
        @(posedge mclk_i);
        pub_o <= 1'b1;
        @(posedge mclk_i);
        pub_o <= 1'b0;
    endtask : pub

    task automatic set_rx(input logic [2:0] v);
        rx_o <= v;
    endtask : set_rx
endmodule : somc_lin_master

// >>> tb/tb_top.sv
// testbench: mode control driven by a lin master model, random data
// assumes: short ms tick so the start window is 30*TICK+1 cycles
`timescale 1ns/100ps
module tb_top
    import somc_pkg::*;
;
    localparam int unsigned TICK = 4;
    localparam int WIN = 30 * TICK + 10;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cfg_pwm = 1'b1;
    logic cfg_hs = 1'b1;
    logic pub;
    logic [15:0] meas = 16'h0000;
    logic fault = 1'b0;
    logic [7:0] fcode = 8'h00;
    logic nvm_req = 1'b0;
    logic pwm_lvl = 1'b0;
    logic tx_en = 1'b0;
    logic tx_bit = 1'b1;
    logic [2:0] rx;
    somc_req_t req;
    somc_mode_t mode;
    somc_resp_t resp;
    logic diag, pwm_act, lin_act, lin_tx, hs_o, hs_oe_n, ls_o, ls_oe_n;
    logic mstart, mnvm, grant, refuse;
    logic [2:0] listen, rxb;
    int error_cnt = 0;
    int n_tests = 0;

    always #2 mclk = ~mclk;

    somc_lin_master u_mst (.mclk_i(mclk), .req_o(req), .pub_o(pub), .rx_o(rx));

    somc_mode_ctrl #(.TICK_CYC(TICK)) u_dut (
        .mclk_i(mclk), .rst_i(rst), .cfg_pwm_mode_i(cfg_pwm),
        .cfg_high_side_i(cfg_hs), .req_i(req), .pub_req_i(pub),
        .meas_value_i(meas), .fault_i(fault), .fault_code_i(fcode),
        .nvm_wr_req_i(nvm_req), .pwm_level_i(pwm_lvl), .link_tx_en_i(tx_en),
        .link_tx_bit_i(tx_bit), .lin_rx_i(rx[0]), .high_side_out_pin_rx_i(rx[1]),
        .low_side_out_pin_rx_i(rx[2]), .mode_o(mode), .diag_o(diag),
        .pwm_active_o(pwm_act), .lin_active_o(lin_act), .listen_o(listen),
        .rx_bits_o(rxb), .lin_tx_o(lin_tx), .high_side_out_pin_o(hs_o),
        .high_side_out_pin_oe_n_o(hs_oe_n), .low_side_out_pin_o(ls_o),
        .low_side_out_pin_oe_n_o(ls_oe_n), .meas_start_o(mstart),
        .meas_from_nvm_o(mnvm), .nvm_wr_grant_o(grant),
        .nvm_wr_refuse_o(refuse), .resp_o(resp));

    function automatic logic [2:0] exp_rx(input logic [2:0] r);
        return {r[2], ~r[1], r[0]};
    endfunction : exp_rx

    function automatic logic [31:0] exp_resp(input logic pubf, input logic err,
        input logic [1:0] pin, input logic [15:0] d);
        return {11'h000, 1'b1, pubf, err, pin, d};
    endfunction : exp_resp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic power_up(input logic pwm, input logic hs);
        rst <= 1'b1;
        cfg_pwm <= pwm;
        cfg_hs <= hs;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : power_up

    task automatic wait_run;
        int n;
        n = 0;
        while (mode !== SOMC_MODE_RUN && n < WIN)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= WIN)
        begin
            error_cnt++;
            results();
        end
    endtask : wait_run

    task automatic nvm_try(input logic [1:0] exp);
        @(posedge mclk);
        nvm_req <= 1'b1;
        @(posedge mclk);
        nvm_req <= 1'b0;
        #1;
        chk({grant, refuse}, exp);
    endtask : nvm_try

    task automatic pwm_set(input logic v);
        @(posedge mclk);
        pwm_lvl <= v;
        #1;
    endtask : pwm_set

    task automatic fail_now(input logic [7:0] c);
        @(posedge mclk);
        fault <= 1'b1;
        fcode <= c;
        @(posedge mclk);
        fault <= 1'b0;
        #1;
        chk({diag, mode}, {1'b1, SOMC_MODE_DIAG});
    endtask : fail_now

    initial
    begin
        logic [7:0] c;
        void'($urandom(61779));
        power_up(1'b1, 1'b1);
        chk({mode, hs_oe_n, ls_oe_n, listen[2:1]}, {SOMC_MODE_WINDOW, 4'hF});
        repeat (8)
        begin
            @(posedge mclk);
            u_mst.set_rx(3'($urandom));
            #1;
            chk(rxb, exp_rx(rx));
        end
        u_mst.set_rx(3'b101);
        wait_run();
        chk({pwm_act, lin_act}, 2'b10);
        chk(listen[2:1], 2'b00);
        pwm_set(1'b1);
        chk({hs_oe_n, ls_oe_n}, 2'b01);
        pwm_set(1'b0);
        chk(hs_oe_n, 1'b1);
        u_mst.enter(PIN_HIGH);
        u_mst.enter(PIN_LOW);
        #1;
        chk(mode, SOMC_MODE_RUN);
        u_mst.enter(PIN_LIN);
        #1;
        chk(mode, SOMC_MODE_COMMAND);
        $display("test pwm window and lock done");

        power_up(1'b1, 1'b0);
        u_mst.send(PIN_LOW, SID_DATA_DUMP, CODE_ENTER_CMD, 16'h75FF);
        #1;
        chk(mode, SOMC_MODE_WINDOW);
        u_mst.enter(PIN_HIGH);
        #1;
        chk(mode, SOMC_MODE_COMMAND);
        @(posedge mclk);
        tx_en <= 1'b1;
        tx_bit <= 1'b0;
        #1;
        chk({hs_oe_n, hs_o, lin_tx}, 3'b011);
        @(posedge mclk);
        tx_bit <= 1'b1;
        #1;
        chk(hs_oe_n, 1'b1);
        @(posedge mclk);
        tx_en <= 1'b0;
        repeat (WIN) @(posedge mclk);
        #1;
        chk(mode, SOMC_MODE_COMMAND);
        nvm_try(2'b01);
        u_mst.unlock();
        nvm_try(2'b10);
        u_mst.send(PIN_LIN, SID_DATA_DUMP, CODE_RUN_NVM, 16'hFFFF);
        #1;
        chk({mode, mstart, mnvm}, {SOMC_MODE_RUN, 2'b11});
        nvm_try(2'b01);
        u_mst.enter(PIN_LIN);
        u_mst.send(PIN_LIN, SID_DATA_DUMP, CODE_RUN_VOLATILE, 16'hFFFF);
        #1;
        chk({mode, mstart, mnvm}, {SOMC_MODE_RUN, 2'b10});
        $display("test command mode done");

        power_up(1'b0, 1'b1);
        @(posedge mclk);
        #1;
        chk({mode, pwm_act, lin_act}, {SOMC_MODE_RUN, 2'b01});
        repeat (4)
        begin
            meas <= 16'($urandom);
            u_mst.pub();
            #1;
            chk(resp, exp_resp(1'b1, 1'b0, PIN_LIN, meas));
        end
        u_mst.enter(PIN_LIN);
        #1;
        chk(mode, SOMC_MODE_COMMAND);
        // dominant reply bit on the lin pin, the PWM pins stay released
        @(posedge mclk);
        tx_en <= 1'b1;
        tx_bit <= 1'b0;
        #1;
        chk({lin_tx, hs_oe_n, ls_oe_n}, 3'b011);
        @(posedge mclk);
        tx_en <= 1'b0;
        tx_bit <= 1'b1;
        u_mst.send(PIN_LIN, SID_DATA_DUMP, CODE_RUN_NVM, 16'hFFFF);
        c = 8'($urandom);
        fail_now(c);
        u_mst.pub();
        #1;
        chk(resp, exp_resp(1'b1, 1'b1, PIN_LIN, meas));
        u_mst.send(PIN_HIGH, SID_READ_BY_ID, ID_ERROR_STATUS, WILDCARD_ERROR);
        #1;
        chk(resp, exp_resp(1'b0, 1'b1, PIN_HIGH, {8'h00, c}));
        $display("test lin run and diagnostics done");

        power_up(1'b1, 1'b1);
        // window is 30 ms ticks plus the start cycle after release
        repeat (30 * TICK) @(posedge mclk);
        #1;
        chk(mode, SOMC_MODE_WINDOW);
        @(posedge mclk);
        #1;
        chk(mode, SOMC_MODE_RUN);
        wait_run();
        c = 8'($urandom);
        fail_now(c);
        pwm_set(1'b1);
        chk({hs_oe_n, ls_oe_n, listen}, 5'b1_1111);
        pwm_set(1'b0);
        u_mst.send(PIN_LOW, SID_READ_BY_ID, ID_ERROR_STATUS, WILDCARD_ERROR);
        #1;
        chk(resp, exp_resp(1'b0, 1'b1, PIN_LOW, {8'h00, c}));
        // dominant reply bit on the low-side pin is not inverted
        @(posedge mclk);
        tx_en <= 1'b1;
        tx_bit <= 1'b0;
        #1;
        chk({ls_oe_n, ls_o, hs_oe_n}, 3'b001);
        @(posedge mclk);
        tx_en <= 1'b0;
        tx_bit <= 1'b1;
        $display("test pwm diagnostics done");
        results();
    end

    initial
    begin
        #400000;
        error_cnt++;
        results();
    end
endmodule : tb_top
